/* File: rtl/inac_device.sv */
// device end: serial register map, indirect memory access, keyed actions
// Notes on behaviour
// R1: write targets memory 0x00-1F, shadow 0x40-5F; slow
// R2: 8-bit read target; memory read about 2 us
// R3: write word built from two 16-bit halves
// R4: write launch bit starts write, reads zero
// R5: write pending flag high during write
// R6: write finished flag set on completion, cleared relaunching
// R7: read launch bit starts read, reads zero
// R8: read pending flag high during read
// R9: read finished set on completion, cleared relaunching
// R10: read result halves valid once finished
// R11: select field clears after action, except margins
// R12: margin codes need unlock and key 0xA5
// R13: reload needs unlock and key 0xA5
// R14: hard reset needs unlock; key 0x5A taken
// R15: turns reset with key 0x46, no unlock
// R16: self-tests with key 0xB9, singly or both
// R17: key field launches action, reads zero
// R18: status clear drops action and boot done
// R19: warning clear drops only previously read bits
// R20: error clear drops only previously read bits
// R21: action done low on launch, high after
// R22: error flags latched until read and cleared
// R23: upper byte of target registers reads zero
// R24: wrong key or missing unlock launches nothing
//
// The Wishbone register port was decided locally.
module inac_device #(
  parameter int NVM_WRITE_CYC = inac_pkg::NVM_WRITE_CYCLES,
  parameter int NVM_READ_CYC = inac_pkg::NVM_READ_CYCLES,
  parameter int ACTION_CYC = inac_pkg::ACTION_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  inac_link_if.device link,
  input wire logic unlocked,
  input wire logic [inac_pkg::FLAG_BITS-1:0] err_event,
  input wire logic [inac_pkg::FLAG_BITS-1:0] warn_event,
  output logic turns_reset,
  output logic hard_reset,
  output logic nvm_reload,
  output logic margin_low,
  output logic margin_high,
  output logic mag_test_run,
  output logic logic_self_test
);
  import inac_pkg::*;

  initial begin
    if (NVM_WRITE_CYC < 1 || NVM_READ_CYC < 1 || ACTION_CYC < 1) begin
      $error("inac_device: cycle counts must be at least one");
    end
  end

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic sclk_prev;
    logic [4:0] bitcnt;
    logic [FRAME_BITS-2:0] shin;
    logic [DATA_BITS-1:0] shout;
    logic [7:0] wtarget;
    logic [7:0] rtarget;
    logic [15:0] write_word_upper_half;
    logic [15:0] write_word_lower_half;
    logic [15:0] read_word_upper_half;
    logic [15:0] read_word_lower_half;
    logic wpend;
    logic wdone;
    logic rpend;
    logic rdone;
    logic [31:0] wtimer;
    logic [31:0] rtimer;
    logic [3:0] sel;
    logic act_busy;
    logic [31:0] atimer;
    logic action_done;
    logic boot_done;
    logic booted;
    logic [FLAG_BITS-1:0] err;
    logic [FLAG_BITS-1:0] warn;
    logic [FLAG_BITS-1:0] err_seen;
    logic [FLAG_BITS-1:0] warn_seen;
    logic turns_reset;
    logic hard_reset;
    logic nvm_reload;
    logic margin_low;
    logic margin_high;
    logic mag_run;
    logic logic_run;
    logic [63:0][31:0] mem;
  } inac_dev_state_t;

  inac_dev_state_t s;
  inac_dev_state_t n;

  function automatic logic [5:0] mem_index(input logic [7:0] a);
    return {a[6], a[4:0]};
  endfunction

  function automatic logic key_ok(input logic [3:0] sel, input logic [7:0] key,
                                  input logic unl);
    logic ok;
    ok = 1'b0;
    case (sel)
      SEL_MARGIN_LOW, SEL_MARGIN_HIGH, SEL_RELOAD: ok = unl && key == KEY_MEMORY; // [R12] [R13] [R24]
      SEL_HARD_RESET: ok = unl && key == KEY_HARD_RESET; // [R14] [R24]
      SEL_TURNS_RESET: ok = key == KEY_TURNS; // [R15]
      SEL_MAG_TEST, SEL_LOGIC_TEST, SEL_BOTH_TESTS: ok = key == KEY_SELF_TEST; // [R16]
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [15:0] rd_word(input inac_dev_state_t st, input logic [6:0] a);
    logic [15:0] w;
    w = RESET_WORD;
    case (a)
      OFS_WRITE_TARGET: w = {8'h00, st.wtarget}; // [R23]
      OFS_WRITE_UPPER: w = st.write_word_upper_half;
      OFS_WRITE_LOWER: w = st.write_word_lower_half;
      OFS_WRITE_STATE: begin
        w[PENDING_BIT] = st.wpend; // [R4] [R5]
        w[FINISHED_BIT] = st.wdone; // [R6]
      end
      OFS_READ_TARGET: w = {8'h00, st.rtarget}; // [R23]
      OFS_READ_STATE: begin
        w[PENDING_BIT] = st.rpend; // [R7] [R8]
        w[FINISHED_BIT] = st.rdone; // [R9]
      end
      OFS_READ_UPPER: w = st.read_word_upper_half; // [R10]
      OFS_READ_LOWER: w = st.read_word_lower_half; // [R10]
      OFS_ACTION_CTRL: w[SELECT_HI:SELECT_LO] = st.sel; // [R17]
      OFS_STATUS: begin
        w[STA_ACTION_DONE] = st.action_done;
        w[STA_BOOT_DONE] = st.boot_done;
        w[STA_LOGIC_TEST] = st.logic_run;
        w[STA_MAG_TEST] = st.mag_run;
      end
      OFS_ERROR: w[FLAG_BITS-1:0] = st.err;
      OFS_WARNING: w[FLAG_BITS-1:0] = st.warn;
      default: w = RESET_WORD;
    endcase
    return w;
  endfunction

  logic rise;
  logic fall;
  logic [6:0] waddr;
  logic [15:0] wdata;
  logic [6:0] raddr;

  always_comb begin
    n = s;
    rise = s.sclk_sync[1] & ~s.sclk_prev;
    fall = ~s.sclk_sync[1] & s.sclk_prev;
    waddr = s.shin[21:15];
    wdata = {s.shin[14:0], s.mosi_sync[1]};
    raddr = {s.shin[5:0], s.mosi_sync[1]};
    n.sclk_sync = {s.sclk_sync[0], link.sclk};
    n.cs_sync = {s.cs_sync[0], link.cs_n};
    n.mosi_sync = {s.mosi_sync[0], link.mosi};
    n.sclk_prev = s.sclk_sync[1];
    n.turns_reset = 1'b0;
    n.hard_reset = 1'b0;
    n.nvm_reload = 1'b0;
    if (!s.booted) begin
      n.booted = 1'b1;
      n.boot_done = 1'b1;
    end
    if (s.wpend) begin
      if (s.wtimer <= 32'h0000_0001) begin
        n.wpend = 1'b0; // [R5]
        n.wdone = 1'b1; // [R6]
        if (nvm_target(s.wtarget) || shadow_target(s.wtarget)) begin // [R1]
          n.mem[mem_index(s.wtarget)] = {s.write_word_upper_half,
                                         s.write_word_lower_half}; // [R3]
        end
      end else begin
        n.wtimer = s.wtimer - 32'h0000_0001;
      end
    end
    if (s.rpend) begin
      if (s.rtimer <= 32'h0000_0001) begin
        n.rpend = 1'b0; // [R8]
        n.rdone = 1'b1; // [R9]
        if (nvm_target(s.rtarget) || shadow_target(s.rtarget)) begin // [R2]
          {n.read_word_upper_half, n.read_word_lower_half} = s.mem[mem_index(s.rtarget)];
        end else begin
          {n.read_word_upper_half, n.read_word_lower_half} = 32'h0000_0000;
        end
      end else begin
        n.rtimer = s.rtimer - 32'h0000_0001;
      end
    end
    if (s.act_busy) begin
      if (s.atimer <= 32'h0000_0001) begin
        n.act_busy = 1'b0;
        n.action_done = 1'b1; // [R21]
        n.mag_run = 1'b0;
        n.logic_run = 1'b0;
        if (s.sel != SEL_MARGIN_LOW && s.sel != SEL_MARGIN_HIGH) begin
          n.sel = SEL_NONE; // [R11]
        end
      end else begin
        n.atimer = s.atimer - 32'h0000_0001;
      end
    end
    if (s.cs_sync[1]) begin
      n.bitcnt = 5'h00;
    end else if (rise) begin
      n.shin = {s.shin[FRAME_BITS-3:0], s.mosi_sync[1]};
      n.bitcnt = s.bitcnt + 5'h01;
      if (s.bitcnt == 5'(ADDR_BITS) && !s.shin[6]) begin
        n.shout = rd_word(s, raddr);
        // snapshot of flags the host has now seen
        if (raddr == OFS_ERROR) begin
          n.err_seen = s.err; // [R20]
        end
        if (raddr == OFS_WARNING) begin
          n.warn_seen = s.warn; // [R19]
        end
      end
      if (s.bitcnt == 5'(FRAME_BITS - 1) && s.shin[22]) begin
        case (waddr)
          OFS_WRITE_TARGET: n.wtarget = wdata[7:0]; // [R23]
          OFS_WRITE_UPPER: n.write_word_upper_half = wdata; // [R3]
          OFS_WRITE_LOWER: n.write_word_lower_half = wdata; // [R3]
          OFS_WRITE_STATE: begin
            if (wdata[LAUNCH_BIT] && !s.wpend) begin
              n.wpend = 1'b1; // [R4]
              n.wdone = 1'b0; // [R4] [R6]
              n.wtimer = nvm_target(s.wtarget) ? 32'(NVM_WRITE_CYC) : 32'(SHADOW_CYCLES); // [R1]
            end
          end
          OFS_READ_TARGET: n.rtarget = wdata[7:0]; // [R2] [R23]
          OFS_READ_STATE: begin
            if (wdata[LAUNCH_BIT] && !s.rpend) begin
              n.rpend = 1'b1; // [R7]
              n.rdone = 1'b0; // [R9]
              n.rtimer = nvm_target(s.rtarget) ? 32'(NVM_READ_CYC) : 32'(SHADOW_CYCLES); // [R2]
            end
          end
          OFS_ACTION_CTRL: begin
            // an action already running keeps its select code
            if (!s.act_busy) begin
              n.sel = wdata[SELECT_HI:SELECT_LO]; // [R11]
              n.margin_low = 1'b0;
              n.margin_high = 1'b0;
              if (key_ok(wdata[SELECT_HI:SELECT_LO], wdata[KEY_HI:0], unlocked)) begin // [R17]
                n.act_busy = 1'b1;
                n.atimer = 32'(ACTION_CYC);
                n.action_done = 1'b0; // [R21]
                case (wdata[SELECT_HI:SELECT_LO])
                  SEL_MARGIN_LOW: n.margin_low = 1'b1; // [R12]
                  SEL_MARGIN_HIGH: n.margin_high = 1'b1; // [R12]
                  SEL_TURNS_RESET: n.turns_reset = 1'b1; // [R15]
                  SEL_RELOAD: n.nvm_reload = 1'b1; // [R13]
                  SEL_HARD_RESET: n.hard_reset = 1'b1; // [R14]
                  SEL_MAG_TEST: n.mag_run = 1'b1; // [R16]
                  SEL_LOGIC_TEST: n.logic_run = 1'b1; // [R16]
                  SEL_BOTH_TESTS: begin
                    n.mag_run = 1'b1; // [R16]
                    n.logic_run = 1'b1; // [R16]
                  end
                  default: n.act_busy = 1'b0;
                endcase
              end
            end
            if (wdata[STATUS_CLEAR_BIT]) begin
              n.action_done = 1'b0; // [R18]
              n.boot_done = 1'b0; // [R18]
            end
            if (wdata[WARNING_CLEAR_BIT]) begin
              n.warn = s.warn & ~s.warn_seen; // [R19]
              n.warn_seen = '0;
            end
            if (wdata[ERROR_CLEAR_BIT]) begin
              n.err = s.err & ~s.err_seen; // [R20]
              n.err_seen = '0;
            end
          end
          default: n.wtarget = s.wtarget;
        endcase
      end
    end else if (fall && s.bitcnt >= 5'(MISO_FIRST_RISE)) begin
      n.shout = {s.shout[DATA_BITS-2:0], 1'b0};
    end
    // new events win over a clear in the same cycle
    n.err = n.err | err_event; // [R22]
    n.warn = n.warn | warn_event;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.sclk_sync <= 2'h0;
      s.cs_sync <= 2'h3;
      s.mosi_sync <= 2'h0;
    end else begin
      s <= n;
    end
  end

  assign link.miso = s.shout[DATA_BITS-1];
  assign turns_reset = s.turns_reset;
  assign hard_reset = s.hard_reset;
  assign nvm_reload = s.nvm_reload;
  assign margin_low = s.margin_low;
  assign margin_high = s.margin_high;
  assign mag_test_run = s.mag_run;
  assign logic_self_test = s.logic_run;
endmodule

/* File: rtl/inac_pkg.sv */
// shared constants for the indirect memory access link and its two ends
package inac_pkg;
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS = 7;
  localparam int DATA_BITS = 16;
  localparam int MISO_FIRST_RISE = 9;

  localparam logic [6:0] OFS_WRITE_TARGET = 7'h02;
  localparam logic [6:0] OFS_WRITE_UPPER = 7'h04;
  localparam logic [6:0] OFS_WRITE_LOWER = 7'h06;
  localparam logic [6:0] OFS_WRITE_STATE = 7'h08;
  localparam logic [6:0] OFS_READ_TARGET = 7'h0a;
  localparam logic [6:0] OFS_READ_STATE = 7'h0c;
  localparam logic [6:0] OFS_READ_UPPER = 7'h0e;
  localparam logic [6:0] OFS_READ_LOWER = 7'h10;
  localparam logic [6:0] OFS_ACTION_CTRL = 7'h1e;
  localparam logic [6:0] OFS_STATUS = 7'h22;
  localparam logic [6:0] OFS_ERROR = 7'h24;
  localparam logic [6:0] OFS_WARNING = 7'h26;

  localparam int LAUNCH_BIT = 15;
  localparam int PENDING_BIT = 8;
  localparam int FINISHED_BIT = 0;
  localparam int STATUS_CLEAR_BIT = 10;
  localparam int WARNING_CLEAR_BIT = 9;
  localparam int ERROR_CLEAR_BIT = 8;
  localparam int SELECT_HI = 15;
  localparam int SELECT_LO = 12;
  localparam int KEY_HI = 7;
  localparam int STA_ACTION_DONE = 5;
  localparam int STA_BOOT_DONE = 4;
  localparam int STA_LOGIC_TEST = 3;
  localparam int STA_MAG_TEST = 2;
  localparam int FLAG_BITS = 12;

  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_MARGIN_LOW = 4'h1;
  localparam logic [3:0] SEL_MARGIN_HIGH = 4'h2;
  localparam logic [3:0] SEL_TURNS_RESET = 4'h4;
  localparam logic [3:0] SEL_RELOAD = 4'h5;
  localparam logic [3:0] SEL_HARD_RESET = 4'h7;
  localparam logic [3:0] SEL_MAG_TEST = 4'h9;
  localparam logic [3:0] SEL_LOGIC_TEST = 4'ha;
  localparam logic [3:0] SEL_BOTH_TESTS = 4'hb;
  localparam logic [7:0] KEY_MEMORY = 8'ha5;
  localparam logic [7:0] KEY_HARD_RESET = 8'h5a;
  localparam logic [7:0] KEY_TURNS = 8'h46;
  localparam logic [7:0] KEY_SELF_TEST = 8'hb9;

  localparam int CLK_MHZ = 250;
  localparam int NVM_WRITE_MS = 24;
  localparam int NVM_READ_US = 2;
  localparam int NVM_WRITE_CYCLES = NVM_WRITE_MS * 1000 * CLK_MHZ;
  localparam int NVM_READ_CYCLES = NVM_READ_US * CLK_MHZ;
  localparam int SHADOW_CYCLES = 1;
  localparam int ACTION_CYCLES = 64;

  localparam logic [3:0] HOST_CMD_OFS = 4'h0;
  localparam logic [3:0] HOST_STATUS_OFS = 4'h4;
  localparam int HOST_HALF_PERIOD = 6;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  function automatic logic nvm_target(input logic [7:0] a);
    return a[7:5] == 3'h0;
  endfunction

  function automatic logic shadow_target(input logic [7:0] a);
    return a[7:5] == 3'h2;
  endfunction
endpackage

/* File: rtl/inac_link_if.sv */
// four-wire serial link between host controller and device end
interface inac_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

/* File: rtl/inac_host.sv */
// host end: wishbone command registers driving serial frames to the device
module inac_host #(
  parameter int HALF_PERIOD = inac_pkg::HOST_HALF_PERIOD
) (
  input wire logic mclk,
  input wire logic reset,
  inac_link_if.host link,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [3:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack
);
  import inac_pkg::*;

  initial begin
    if (HALF_PERIOD < 4 || HALF_PERIOD > 255) begin
      $error("inac_host: half period must be 4 to 255 cycles");
    end
  end

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LOW = 5'b00010,
    ST_HIGH = 5'b00100,
    ST_TAIL = 5'b01000,
    ST_GAP = 5'b10000
  } inac_host_state_t;

  typedef struct packed {
    inac_host_state_t st;
    logic [7:0] div;
    logic [4:0] cnt;
    logic [FRAME_BITS-1:0] cmd;
    logic [FRAME_BITS-1:0] tx;
    logic [DATA_BITS-1:0] rx;
    logic busy;
    logic [1:0] miso_sync;
    logic ack;
    logic [31:0] dat;
    logic sclk;
    logic cs_n;
    logic mosi;
  } inac_host_regs_t;

  inac_host_regs_t s;
  inac_host_regs_t n;
  logic start;
  logic [7:0] half;

  always_comb begin
    n = s;
    start = 1'b0;
    half = 8'(HALF_PERIOD - 1);
    n.miso_sync = {s.miso_sync[0], link.miso};
    n.ack = 1'b0;
    if (wb_cyc && wb_stb && !s.ack) begin
      n.ack = 1'b1;
      n.dat = 32'h0000_0000;
      case (wb_adr)
        HOST_CMD_OFS: begin
          n.dat = {8'h00, s.cmd};
          // a command written during a frame is dropped, not queued
          if (wb_we && !s.busy) begin
            if (wb_sel[0]) n.cmd[7:0] = wb_dat_w[7:0];
            if (wb_sel[1]) n.cmd[15:8] = wb_dat_w[15:8];
            if (wb_sel[2]) n.cmd[23:16] = wb_dat_w[23:16];
            start = 1'b1;
          end
        end
        HOST_STATUS_OFS: n.dat = {s.rx, 15'h0000, s.busy}; // [R10]
        default: n.dat = 32'h0000_0000;
      endcase
    end
    case (s.st)
      ST_IDLE: begin
        n.sclk = 1'b0;
        n.cs_n = 1'b1;
        if (start) begin
          n.tx = n.cmd;
          n.mosi = n.cmd[FRAME_BITS-1];
          n.cs_n = 1'b0;
          n.cnt = 5'h00;
          n.div = half;
          n.busy = 1'b1; // [R1]
          n.st = ST_LOW;
        end
      end
      ST_LOW: begin
        if (s.div == 8'h00) begin
          n.sclk = 1'b1;
          n.cnt = s.cnt + 5'h01;
          n.div = half;
          n.st = ST_HIGH;
        end else begin
          n.div = s.div - 8'h01;
        end
      end
      ST_HIGH: begin
        if (s.div == 8'h00) begin
          n.sclk = 1'b0;
          n.div = half;
          if (s.cnt >= 5'(MISO_FIRST_RISE)) begin
            n.rx = {s.rx[DATA_BITS-2:0], s.miso_sync[1]}; // [R10]
          end
          if (s.cnt == 5'(FRAME_BITS)) begin
            n.st = ST_TAIL;
          end else begin
            n.tx = {s.tx[FRAME_BITS-2:0], 1'b0};
            n.mosi = s.tx[FRAME_BITS-2];
            n.st = ST_LOW;
          end
        end else begin
          n.div = s.div - 8'h01;
        end
      end
      ST_TAIL: begin
        if (s.div == 8'h00) begin
          n.cs_n = 1'b1;
          n.div = half;
          n.st = ST_GAP;
        end else begin
          n.div = s.div - 8'h01;
        end
      end
      ST_GAP: begin
        if (s.div == 8'h00) begin
          n.busy = 1'b0;
          n.st = ST_IDLE;
        end else begin
          n.div = s.div - 8'h01;
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.cs_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.sclk = s.sclk;
  assign link.cs_n = s.cs_n;
  assign link.mosi = s.mosi;
  assign wb_dat_r = s.dat;
  assign wb_ack = s.ack;
endmodule

/* File: testbench/inac_chk.sv */
// link assertions for the serial frame between host and device ends
module inac_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  logic [5:0] rises;
  // rises seen in the current frame, cleared between frames
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rises <= 6'h00;
    end else if (cs_n) begin
      rises <= 6'h00;
    end else if ($rose(sclk)) begin
      rises <= rises + 6'h01;
    end
  end
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("link clock runs outside a frame");
  a_high_phase: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
    else $error("link clock high phase is not six cycles");
  a_low_phase: assert property ($fell(sclk) |-> !sclk [*6])
    else $error("link clock low phase is short");
  a_first_rise: assert property ($fell(cs_n) |-> !sclk [*6] ##1 sclk)
    else $error("first link clock rise misplaced");
  a_mosi_hold: assert property (sclk |-> $stable(mosi))
    else $error("host data moved while link clock high");
  a_frame_length: assert property ($rose(cs_n) |-> rises == 6'd24)
    else $error("frame did not carry 24 clock rises");
  a_gap_length: assert property ($rose(cs_n) |-> cs_n [*6])
    else $error("gap between frames is short");
  // the load after rise 8 may move miso early, so only later bits are held
  a_miso_hold: assert property (!cs_n && sclk && rises > 6'd9 |-> $stable(miso))
    else $error("device data moved while link clock high");
endmodule

/* File: testbench/tb.sv */
// self-checking bench: host and device ends joined over the serial link
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import inac_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0000_0000;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic unlocked = 1'b0;
  logic [11:0] err_event = 12'h000;
  logic [11:0] warn_event = 12'h000;
  wire [6:0] outs;
  logic [6:0] prev = 7'h00;
  logic [6:0] seen = 7'h00;
  logic clr_seen = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  inac_link_if link();
  inac_host inac_host_inst (.mclk(mclk), .reset(reset), .link(link), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));
  // memory write count shortened and read count lengthened, both longer than a frame so pending shows
  inac_device #(.NVM_WRITE_CYC(2000), .NVM_READ_CYC(1000), .ACTION_CYC(8)) inac_device_inst (
    .mclk(mclk), .reset(reset), .link(link), .unlocked(unlocked), .err_event(err_event),
    .warn_event(warn_event), .turns_reset(outs[0]), .hard_reset(outs[1]),
    .nvm_reload(outs[2]), .margin_low(outs[3]), .margin_high(outs[4]),
    .mag_test_run(outs[5]), .logic_self_test(outs[6]));
  inac_chk inac_chk_inst (.mclk(mclk), .reset(reset), .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso(link.miso));

  always #2 mclk = ~mclk;

  // rising edges only, so a margin level left from before is not seen again
  always @(posedge mclk) begin
    prev <= outs;
    seen <= clr_seen ? 7'h00 : (seen | (outs & ~prev));
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
    output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hf;
    wb_adr <= adr;
    wb_dat_w <= d;
    // no own limit: only the bench timeout ends a hung wait
    do begin
      @(posedge mclk);
    end while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge mclk);
  endtask

  // one device frame, then poll host busy until the frame is over
  task automatic dev(input logic w, input logic [6:0] a, input logic [15:0] d,
    output logic [15:0] q);
    logic [31:0] r;
    wb(1'b1, HOST_CMD_OFS, {8'h00, w, a, d}, r);
    do begin
      wb(1'b0, HOST_STATUS_OFS, 32'h0000_0000, r);
    end while (r[0] !== 1'b0);
    q = r[31:16];
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] q;
    dev(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] q;
    dev(1'b0, a, 16'h0000, q);
    chk(name, exp, q);
  endtask

  task automatic poll(input logic [6:0] a, output logic [15:0] q);
    do begin
      dev(1'b0, a, 16'h0000, q);
    end while (q === 16'h0100);
  endtask

  task automatic t_regs();
    rd_chk("boot status", OFS_STATUS, 16'h0010);
    wr(OFS_WRITE_TARGET, 16'hffff);
    rd_chk("write target", OFS_WRITE_TARGET, 16'h00ff);
    wr(OFS_READ_TARGET, 16'hff5a);
    rd_chk("read target", OFS_READ_TARGET, 16'h005a);
    wr(OFS_WRITE_UPPER, 16'hbeef);
    wr(OFS_WRITE_LOWER, 16'hcafe);
    rd_chk("upper half", OFS_WRITE_UPPER, 16'hbeef);
    rd_chk("lower half", OFS_WRITE_LOWER, 16'hcafe);
    rd_chk("unmapped", 7'h12, 16'h0000);
  endtask

  task automatic t_shadow();
    wr(OFS_WRITE_TARGET, 16'h0045);
    wr(OFS_WRITE_STATE, 16'h8000);
    rd_chk("write state", OFS_WRITE_STATE, 16'h0001);
    wr(OFS_READ_TARGET, 16'h0045);
    wr(OFS_READ_STATE, 16'h8000);
    rd_chk("read state", OFS_READ_STATE, 16'h0001);
    rd_chk("result upper", OFS_READ_UPPER, 16'hbeef);
    rd_chk("result lower", OFS_READ_LOWER, 16'hcafe);
  endtask

  task automatic t_nvm();
    logic [15:0] q;
    wr(OFS_WRITE_UPPER, 16'h1357);
    wr(OFS_WRITE_LOWER, 16'h2468);
    wr(OFS_WRITE_TARGET, 16'h001f);
    wr(OFS_WRITE_STATE, 16'h8000);
    rd_chk("write pending", OFS_WRITE_STATE, 16'h0100);
    poll(OFS_WRITE_STATE, q);
    chk("write done", 16'h0001, q);
    wr(OFS_READ_TARGET, 16'h001f);
    wr(OFS_READ_STATE, 16'h8000);
    rd_chk("read pending", OFS_READ_STATE, 16'h0100);
    poll(OFS_READ_STATE, q);
    chk("read done", 16'h0001, q);
    rd_chk("memory upper", OFS_READ_UPPER, 16'h1357);
    rd_chk("memory lower", OFS_READ_LOWER, 16'h2468);
  endtask

  // bits of exp: turns, hard reset, reload, margin low, margin high, mag, logic
  task automatic act(input logic [3:0] sel, input logic [7:0] key, input logic unl,
    input logic [6:0] exp);
    unlocked <= unl;
    clr_seen <= 1'b1;
    @(posedge mclk);
    clr_seen <= 1'b0;
    wr(OFS_ACTION_CTRL, {sel, 4'h0, key});
    chk("action outputs", {9'h000, exp}, {9'h000, seen});
    if (exp !== 7'h00) begin
      rd_chk("action done", OFS_STATUS, 16'h0030);
      rd_chk("select field", OFS_ACTION_CTRL, exp[4:3] != 2'b00 ? {sel, 12'h000} : 16'h0000);
    end
  endtask

  task automatic t_acts();
    act(SEL_TURNS_RESET, KEY_TURNS, 1'b0, 7'h01);
    act(SEL_RELOAD, KEY_MEMORY, 1'b1, 7'h04);
    act(SEL_HARD_RESET, KEY_HARD_RESET, 1'b1, 7'h02);
    act(SEL_MARGIN_LOW, KEY_MEMORY, 1'b1, 7'h08);
    act(SEL_MARGIN_HIGH, KEY_MEMORY, 1'b1, 7'h10);
    act(SEL_MAG_TEST, KEY_SELF_TEST, 1'b0, 7'h20);
    act(SEL_LOGIC_TEST, KEY_SELF_TEST, 1'b0, 7'h40);
    act(SEL_BOTH_TESTS, KEY_SELF_TEST, 1'b0, 7'h60);
    act(SEL_RELOAD, KEY_MEMORY, 1'b0, 7'h00);
    act(SEL_MARGIN_LOW, KEY_MEMORY, 1'b0, 7'h00);
    act(SEL_TURNS_RESET, KEY_MEMORY, 1'b0, 7'h00);
    act(SEL_HARD_RESET, KEY_MEMORY, 1'b1, 7'h00);
    act(SEL_HARD_RESET, KEY_HARD_RESET, 1'b0, 7'h00);
  endtask

  task automatic pulse(input logic e, input logic [11:0] v);
    if (e) err_event <= v;
    else warn_event <= v;
    @(posedge mclk);
    err_event <= 12'h000;
    warn_event <= 12'h000;
  endtask

  // only the flag read before the clear may go; the later one must stay
  task automatic t_flag(input logic e, input logic [6:0] ofs, input logic [15:0] clr);
    pulse(e, 12'h008);
    rd_chk("flags latched", ofs, 16'h0008);
    pulse(e, 12'h002);
    wr(OFS_ACTION_CTRL, clr);
    rd_chk("flags cleared", ofs, 16'h0002);
    rd_chk("clear bits", OFS_ACTION_CTRL, 16'h0000);
  endtask

  task automatic t_clear();
    wr(OFS_ACTION_CTRL, 16'h0400);
    rd_chk("status cleared", OFS_STATUS, 16'h0000);
    t_flag(1'b1, OFS_ERROR, 16'h0100);
    t_flag(1'b0, OFS_WARNING, 16'h0200);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    t_regs();
    t_shadow();
    t_nvm();
    t_acts();
    t_clear();
    final_report();
  end
endmodule
